// ---- design/adia_irq_agg.sv ----
// module: interrupt source mirror, priority vector and interrupt output
`timescale 1ns/100ps
module adia_irq_agg (
	input  wire logic                             core_clk,
	input  wire logic                             rst_n,
	input  wire logic                             reg_rd_en,
	input  wire logic [adia_pkg::ADIA_ADDR_W-1:0] reg_addr,
	input  wire logic                             reg_word,
	output logic [adia_pkg::ADIA_DATA_W-1:0]      reg_rdata,
	output logic                                  reg_rvalid,
	input  wire logic                             normal_mode,
	input  wire logic                             stop_wake,
	input  wire logic                             low_battery_cond,
	input  wire logic                             low_supply1_cond,
	input  wire logic                             high_supply2_cond,
	input  wire logic                             regulator_hot_cond,
	input  wire logic                             regulator_overvolt_cond,
	input  wire logic                             timer_chan_0_req,
	input  wire logic                             timer_chan_1_req,
	input  wire logic                             timer_chan_2_req,
	input  wire logic                             timer_chan_3_req,
	input  wire logic                             timer_wrap_req,
	input  wire logic                             sci_error_req,
	input  wire logic                             sci_tx_req,
	input  wire logic                             sci_rx_req,
	input  wire logic                             adc_sequence_done_req,
	input  wire logic                             bus_driver_overheat_req,
	input  wire logic                             high_side_overheat_req,
	input  wire logic                             low_side_overheat_req,
	input  wire logic                             hall_supply_overheat_req,
	output logic [adia_pkg::ADIA_NUM_VOLT-1:0]    voltage_warn_flags,
	output logic                                  die_link_irq_out
);
	import adia_pkg::*;

	adia_volt_if #(.N(ADIA_NUM_VOLT)) vif ();

	logic [ADIA_NUM_VOLT-1:0] low_warn;
	logic                     low_battery_warn;
	logic                     low_supply1_warn;
	logic                     high_supply2_warn;
	logic                     regulator_hot_warn;
	logic                     regulator_overvolt_warn;
	logic                     voltage_status_combined;
	logic [ADIA_DATA_W-1:0]   pending_source_mirror;
	logic [ADIA_VEC_W-1:0]    priority_vector_code;
	logic [ADIA_NUM_PRIO-1:0] prio_req;
	logic [ADIA_DATA_W-1:0]   rdata_r;
	logic [ADIA_DATA_W-1:0]   rdata_nxt;
	logic                     rvalid_r;
	logic                     rvalid_nxt;
	logic                     irq_r;
	logic                     irq_nxt;
	logic                     vstatus_rd;

	// lowest index wins; code is the doubled priority number, which is the index plus one
	function automatic logic [5:0] adia_encode(input logic [ADIA_NUM_PRIO-1:0] req);
		logic [5:0] code;
		code = ADIA_VEC_NONE;
		for (int i = ADIA_NUM_PRIO - 1; i >= 0; i--)
		begin
			if (req[i])
				code = 6'((i + 1) * 2);
		end
		return code;
	endfunction : adia_encode

	adia_volt_latch #(.N(ADIA_NUM_VOLT)) u_volt_latch (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.vif      (vif)
	);

	// the voltage status register itself lives in the power block; its read is watched here
	assign vstatus_rd = reg_rd_en && (reg_addr == ADIA_OFS_VSTATUS);

	always_comb
	begin
		vif.cond                 = '0;
		vif.cond[ADIA_V_LOWBAT]  = low_battery_cond;
		vif.cond[ADIA_V_LOWSUP]  = low_supply1_cond;
		vif.cond[ADIA_V_HIGHSUP] = high_supply2_cond;
		vif.cond[ADIA_V_REGHOT]  = regulator_hot_cond;
		vif.cond[ADIA_V_REGOV]   = regulator_overvolt_cond;
		vif.clr                  = vstatus_rd;
	end

	assign low_warn                = vif.warn;
	assign low_battery_warn        = low_warn[ADIA_V_LOWBAT];
	assign low_supply1_warn        = low_warn[ADIA_V_LOWSUP];
	assign high_supply2_warn       = low_warn[ADIA_V_HIGHSUP];
	assign regulator_hot_warn      = low_warn[ADIA_V_REGHOT];
	assign regulator_overvolt_warn = low_warn[ADIA_V_REGOV];
	assign voltage_status_combined = |low_warn;

	// mirror and vector are pure functions of this cycle's pending inputs
	always_comb
	begin
		pending_source_mirror                   = ADIA_MIRROR_RST;
		pending_source_mirror[ADIA_M_VOLT]      = voltage_status_combined;
		pending_source_mirror[ADIA_M_TCH0]      = timer_chan_0_req;
		pending_source_mirror[ADIA_M_TCH0 + 1]  = timer_chan_1_req;
		pending_source_mirror[ADIA_M_TCH0 + 2]  = timer_chan_2_req;
		pending_source_mirror[ADIA_M_TCH0 + 3]  = timer_chan_3_req;
		pending_source_mirror[ADIA_M_TWRAP]     = timer_wrap_req;
		pending_source_mirror[ADIA_M_SERR]      = sci_error_req;
		pending_source_mirror[ADIA_M_STX]       = sci_tx_req;
		pending_source_mirror[ADIA_M_SRX]       = sci_rx_req;
		pending_source_mirror[ADIA_M_ADC]       = adc_sequence_done_req;
		pending_source_mirror[ADIA_M_BUSHOT]    = bus_driver_overheat_req;
		pending_source_mirror[ADIA_M_HSHOT]     = high_side_overheat_req;
		pending_source_mirror[ADIA_M_LSHOT]     = low_side_overheat_req;
		pending_source_mirror[ADIA_M_HALLHOT]   = hall_supply_overheat_req;
	end

	// encoder order: voltage warnings ranked one by one, not the combined bit
	always_comb
	begin
		prio_req = {
			regulator_overvolt_warn,
			high_supply2_warn,
			hall_supply_overheat_req,
			low_side_overheat_req,
			high_side_overheat_req,
			bus_driver_overheat_req,
			adc_sequence_done_req,
			sci_rx_req,
			sci_tx_req,
			sci_error_req,
			timer_wrap_req,
			timer_chan_3_req,
			timer_chan_2_req,
			timer_chan_1_req,
			timer_chan_0_req,
			low_battery_warn,
			regulator_hot_warn,
			low_supply1_warn
		};
		priority_vector_code = ADIA_VEC_RST;
		if (stop_wake)
			priority_vector_code[ADIA_VEC_LSB_W-1:0] = ADIA_VEC_NONE;
		else
			priority_vector_code[ADIA_VEC_LSB_W-1:0] = adia_encode(prio_req);
	end

	// read path; nothing here touches a source's pending state
	always_comb
	begin
		rdata_nxt  = rdata_r;
		rvalid_nxt = reg_rd_en;
		if (reg_rd_en)
		begin
			rdata_nxt = '0;
			// local offsets only; the host adds either global base upstream
			case (reg_addr)
				ADIA_OFS_MIRROR:
				begin
					if (reg_word)
						rdata_nxt = pending_source_mirror;
					else
						rdata_nxt = {8'h00, pending_source_mirror[15:8]};
				end
				ADIA_OFS_MIRROR_B:
				begin
					rdata_nxt = {8'h00, pending_source_mirror[7:0]};
				end
				ADIA_OFS_VECTOR:
				begin
					rdata_nxt = {8'h00, priority_vector_code};
				end
				default:
				begin
					rdata_nxt = '0;
				end
			endcase
		end
		// only normal mode signals requests; level stays until the source is served
		irq_nxt = normal_mode && (|pending_source_mirror);
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			rdata_r  <= '0;
			rvalid_r <= 1'b0;
			irq_r    <= 1'b0;
		end
		else
		begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			irq_r    <= irq_nxt;
		end
	end

	// no write path exists: writes from the link never reach these registers
	assign reg_rdata          = rdata_r;
	assign reg_rvalid         = rvalid_r;
	assign die_link_irq_out   = irq_r;
	assign voltage_warn_flags = low_warn;
endmodule : adia_irq_agg

// ---- design/adia_pkg.sv ----
// package: constants of the analog die interrupt aggregator
// Behaviour
// - mirror bit 0 is the OR of the five latched voltage warnings
// - every interrupt source shows as a read-only pending bit in the mirror
// - reading the mirror clears nothing; host services the source module itself
// - timer channels 0..3 at mirror bits 1..4, timer wrap at bit 5
// - serial error, transmit, receive at mirror bits 6, 7, 8
// - ADC sequence done at mirror bit 9
// - overheat bits: bus driver 10, high side 11, low side 12, hall 13
// - mirror is a 16-bit word at 0x00, bytes readable at 0x00 and 0x01
// - host sees offsets on base 0x0200 blocking or 0x300 non-blocking
// - vector returns highest pending source code, pre-doubled for word tables
// - vector code in bits 5:0, zero when nothing pending
// - stop-state wake-up returns code 0x00 at highest priority
// - low supply 0x02, regulator hot 0x04, low battery 0x06 in that order
// - timer channels 0..3 give 0x08..0x0e, timer wrap 0x10
// - serial error 0x12, transmit 0x14, receive 0x16, ADC done 0x18
// - overheat codes: bus driver 0x1a, high 0x1c, low 0x1e, hall 0x20
// - high supply 0x22, regulator overvolt 0x24 at lowest priority
// - smallest priority number wins among pending sources, 1 highest, 18 lowest
// - reading the vector clears nothing; host services the source module
// - combined voltage bit only in mirror; encoder ranks five voltage warnings apart
// - voltage warning acknowledged by status read; re-raised only after condition recurs
// - interrupt output high while any request pending, only in normal mode
// - voltage status read clears every latched voltage warning present
package adia_pkg;
	localparam int          ADIA_ADDR_W       = 8;
	localparam int          ADIA_DATA_W       = 16;
	localparam int          ADIA_VEC_W        = 8;
	localparam int          ADIA_NUM_VOLT     = 5;
	localparam int          ADIA_NUM_PRIO     = 18;
	localparam logic [15:0] ADIA_BASE_BLOCK   = 16'h0200;
	localparam logic [15:0] ADIA_BASE_NONBLK  = 16'h0300;
	localparam logic [7:0]  ADIA_OFS_MIRROR   = 8'h00;
	localparam logic [7:0]  ADIA_OFS_MIRROR_B = 8'h01;
	localparam logic [7:0]  ADIA_OFS_VECTOR   = 8'h02;
	localparam logic [7:0]  ADIA_OFS_VSTATUS  = 8'h04;
	// voltage warning positions, same as in the voltage status register
	localparam int          ADIA_V_LOWBAT     = 0;
	localparam int          ADIA_V_LOWSUP     = 1;
	localparam int          ADIA_V_HIGHSUP    = 2;
	localparam int          ADIA_V_REGHOT     = 3;
	localparam int          ADIA_V_REGOV      = 4;
	// mirror bit positions
	localparam int          ADIA_M_VOLT       = 0;
	localparam int          ADIA_M_TCH0       = 1;
	localparam int          ADIA_M_TWRAP      = 5;
	localparam int          ADIA_M_SERR       = 6;
	localparam int          ADIA_M_STX        = 7;
	localparam int          ADIA_M_SRX        = 8;
	localparam int          ADIA_M_ADC        = 9;
	localparam int          ADIA_M_BUSHOT     = 10;
	localparam int          ADIA_M_HSHOT      = 11;
	localparam int          ADIA_M_LSHOT      = 12;
	localparam int          ADIA_M_HALLHOT    = 13;
	localparam int          ADIA_VEC_LSB_W    = 6;
	localparam logic [5:0]  ADIA_VEC_NONE     = 6'h00;
	localparam logic [5:0]  ADIA_VEC_STEP     = 6'h02;
	localparam logic [15:0] ADIA_MIRROR_RST   = 16'h0000;
	localparam logic [7:0]  ADIA_VEC_RST      = 8'h00;
endpackage : adia_pkg

// ---- design/adia_volt_if.sv ----
// interface: voltage conditions in, latched warnings out, clear strobe
`timescale 1ns/100ps
interface adia_volt_if #(
	parameter int N = 5
);
	logic [N-1:0] cond;
	logic         clr;
	logic [N-1:0] warn;

	modport agg (output cond, output clr, input warn);
	modport latch (input cond, input clr, output warn);
endinterface : adia_volt_if

// ---- design/adia_volt_latch.sv ----
// module: edge-latched voltage warnings cleared by a status read
`timescale 1ns/100ps
module adia_volt_latch #(
	parameter int N = 5
) (
	input  wire logic   core_clk,
	input  wire logic   rst_n,
	adia_volt_if.latch  vif
);
	logic [N-1:0] cond_d_r;
	logic [N-1:0] cond_d_nxt;
	logic [N-1:0] warn_r;
	logic [N-1:0] warn_nxt;

	// elaboration-time refusal of a width the latch cannot serve
	if (N < 1)
	begin : g_bad_width
		$error("adia_volt_latch: N must be at least 1");
	end

	always_comb
	begin
		cond_d_nxt = vif.cond;
		// a rising condition sets the warning, and set beats a clear in the same cycle
		warn_nxt   = (warn_r & ~{N{vif.clr}}) | (vif.cond & ~cond_d_r);
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cond_d_r <= '0;
			warn_r   <= '0;
		end
		else
		begin
			cond_d_r <= cond_d_nxt;
			warn_r   <= warn_nxt;
		end
	end

	assign vif.warn = warn_r;
endmodule : adia_volt_latch

// ---- tb/adia_irq_agg_sva.sv ----
// checker: port relations of the interrupt aggregator
`timescale 1ns/100ps
module adia_irq_agg_sva (
	input wire logic                             core_clk,
	input wire logic                             rst_n,
	input wire logic                             reg_rd_en,
	input wire logic [adia_pkg::ADIA_ADDR_W-1:0] reg_addr,
	input wire logic                             reg_word,
	input wire logic [adia_pkg::ADIA_DATA_W-1:0] reg_rdata,
	input wire logic                             reg_rvalid,
	input wire logic                             normal_mode,
	input wire logic                             stop_wake,
	input wire logic                             timer_chan_0_req,
	input wire logic [4:0]                       voltage_warn_flags,
	input wire logic                             die_link_irq_out
);
	import adia_pkg::*;
	logic mrd;
	logic vrd;
	assign mrd = reg_rd_en && reg_word && reg_addr == ADIA_OFS_MIRROR;
	assign vrd = reg_rd_en && reg_addr == ADIA_OFS_VECTOR;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	chk_read_answered: assert property (reg_rd_en |=> reg_rvalid)
		else $error("read not answered next cycle");
	chk_rvalid_caused: assert property (!reg_rd_en |=> !reg_rvalid)
		else $error("answer without read");
	chk_vector_upper: assert property (vrd |=> reg_rdata[15:6] == 10'h000)
		else $error("vector upper bits set");
	chk_mirror_top: assert property (mrd |=> reg_rdata[15:14] == 2'b00)
		else $error("mirror top bits set");
	chk_mirror_volt: assert property (mrd |=> reg_rdata[0] == $past(|voltage_warn_flags))
		else $error("combined voltage bit wrong");
	chk_mirror_chan0: assert property (mrd && timer_chan_0_req |=> reg_rdata[1])
		else $error("timer channel 0 bit missing");
	chk_wake_code: assert property (vrd && stop_wake |=> reg_rdata == 16'h0000)
		else $error("wake-up code not zero");
	chk_irq_mode: assert property (!normal_mode |=> !die_link_irq_out)
		else $error("irq outside normal mode");
	chk_irq_pending: assert property (normal_mode && |voltage_warn_flags |=> die_link_irq_out)
		else $error("irq low while pending");
	chk_flag_keep: assert property (!(reg_rd_en && reg_addr == ADIA_OFS_VSTATUS)
		|=> (voltage_warn_flags & $past(voltage_warn_flags)) == $past(voltage_warn_flags))
		else $error("warning lost without status read");
	cover property (vrd && stop_wake);
	cover property (die_link_irq_out);
	cover property (reg_rd_en && reg_addr == ADIA_OFS_VSTATUS && |voltage_warn_flags);
endmodule : adia_irq_agg_sva

// ---- tb/adia_host_model.sv ----
// host model: local register reads over the die link
`timescale 1ns/100ps
module adia_host_model (
	input wire logic        core_clk,
	output logic            reg_rd_en,
	output logic [7:0]      reg_addr,
	output logic            reg_word,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_rvalid
);
	initial
	begin
		reg_rd_en = 1'b0;
		reg_addr = 8'hff;
		reg_word = 1'b0;
	end
	// offsets are local, the global base is added upstream
	task automatic rd(input logic [7:0] a, input logic w, output logic [15:0] d);
		d = 16'hxxxx;
		@(negedge core_clk);
		reg_rd_en = 1'b1;
		reg_addr = a;
		reg_word = w;
		@(posedge core_clk);
		@(negedge core_clk);
		reg_rd_en = 1'b0;
		reg_addr = ~a;
		reg_word = ~w;
		for (int i = 0; i < 3; i++)
		begin
			@(posedge core_clk);
			if (reg_rvalid === 1'b1)
			begin
				d = reg_rdata;
				break;
			end
		end
	endtask : rd
endmodule : adia_host_model

// ---- tb/adia_irq_agg_tb_top.sv ----
// testbench top of the interrupt aggregator
`timescale 1ns/100ps
module adia_irq_agg_tb_top;
	import adia_pkg::*;
	localparam logic [7:0] VC [5] = '{8'h06, 8'h02, 8'h22, 8'h04, 8'h24};
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic normal_mode = 1'b0;
	logic stop_wake = 1'b0;
	logic [12:0] src = 13'h0000;
	logic [4:0] cond = 5'h00;
	logic reg_rd_en, reg_word, reg_rvalid, irq;
	logic [7:0] reg_addr;
	logic [15:0] reg_rdata, d;
	logic [4:0] flags;
	int n_errors = 0;
	int samples_checked = 0;
	always #2.5 core_clk = ~core_clk;
	adia_host_model host (.core_clk, .reg_rd_en, .reg_addr, .reg_word, .reg_rdata, .reg_rvalid);
	adia_irq_agg uut (.core_clk, .rst_n, .reg_rd_en, .reg_addr, .reg_word, .reg_rdata,
		.reg_rvalid, .normal_mode, .stop_wake, .low_battery_cond(cond[0]),
		.low_supply1_cond(cond[1]), .high_supply2_cond(cond[2]), .regulator_hot_cond(cond[3]),
		.regulator_overvolt_cond(cond[4]), .timer_chan_0_req(src[0]), .timer_chan_1_req(src[1]),
		.timer_chan_2_req(src[2]), .timer_chan_3_req(src[3]), .timer_wrap_req(src[4]),
		.sci_error_req(src[5]), .sci_tx_req(src[6]), .sci_rx_req(src[7]),
		.adc_sequence_done_req(src[8]), .bus_driver_overheat_req(src[9]),
		.high_side_overheat_req(src[10]), .low_side_overheat_req(src[11]),
		.hall_supply_overheat_req(src[12]), .voltage_warn_flags(flags), .die_link_irq_out(irq));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rc(input logic [7:0] a, input logic w, input logic [15:0] e);
		host.rd(a, w, d);
		chk(d, e);
	endtask : rc
	task automatic t_src;
		logic [15:0] m;
		chk({10'h000, irq, flags}, 16'h0000);
		for (int i = 0; i < 13; i++)
		begin
			m = 16'h0002 << i;
			@(negedge core_clk) src = 13'h0001 << i;
			rc(8'h00, 1'b1, m);
			rc(8'h00, 1'b0, {8'h00, m[15:8]});
			rc(8'h01, 1'b0, {8'h00, m[7:0]});
			rc(8'h02, 1'b1, 16'(8 + 2 * i));
		end
		@(negedge core_clk) src = 13'h0000;
		rc(8'h02, 1'b0, 16'h0000);
		rc(8'h40, 1'b1, 16'h0000);
	endtask : t_src
	task automatic t_volt;
		for (int k = 0; k < 5; k++)
		begin
			@(negedge core_clk) cond = 5'h01 << k;
			rc(8'h00, 1'b1, 16'h0001);
			rc(8'h02, 1'b1, {8'h00, VC[k]});
			chk(16'(flags), 16'(5'h01 << k));
			rc(8'h04, 1'b1, 16'h0000);
			@(negedge core_clk) chk(16'(flags), 16'h0000);
			rc(8'h00, 1'b1, 16'h0000);
			@(negedge core_clk) cond = 5'h00;
		end
		@(negedge core_clk) cond = 5'h01;
		@(negedge core_clk) chk(16'(flags), 16'h0001);
		@(negedge core_clk) cond = 5'h1f;
		rc(8'h02, 1'b1, 16'h0002);
		rc(8'h04, 1'b1, 16'h0000);
		@(negedge core_clk) cond = 5'h00;
	endtask : t_volt
	task automatic t_prio;
		@(negedge core_clk) src = 13'h1fff;
		cond = 5'h10;
		for (int i = 0; i < 13; i++)
		begin
			rc(8'h02, 1'b1, 16'(8 + 2 * i));
			@(negedge core_clk) src[i] = 1'b0;
		end
		rc(8'h02, 1'b1, 16'h0024);
		chk(16'(irq), 16'h0000);
		@(negedge core_clk) normal_mode = 1'b1;
		stop_wake = 1'b1;
		@(negedge core_clk) chk(16'(irq), 16'h0001);
		rc(8'h02, 1'b1, 16'h0000);
		rc(8'h04, 1'b1, 16'h0000);
		repeat (2) @(negedge core_clk);
		chk(16'(irq), 16'h0000);
	endtask : t_prio
	task automatic conclude;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	initial
	begin
		repeat (3) @(negedge core_clk);
		rst_n = 1'b1;
		t_src();
		t_volt();
		t_prio();
		conclude();
	end
	initial
	begin
		#20000;
		n_errors++;
		conclude();
	end
endmodule : adia_irq_agg_tb_top
bind adia_irq_agg adia_irq_agg_sva chk (.core_clk, .rst_n, .reg_rd_en, .reg_addr, .reg_word,
	.reg_rdata, .reg_rvalid, .normal_mode, .stop_wake, .timer_chan_0_req,
	.voltage_warn_flags, .die_link_irq_out);
